// *** core/channel_timing_unit.sv ***
// Sixteen-channel capture/compare unit with two time bases, Wishbone slave.
// Assumes classic Wishbone, one 40 MHz clock, pins synchronous to it.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Up to 16 channels resolve one clock, or eight clocks when staggered.
// - Two independent 16-bit time bases, each with its own reload register.
// - Each time base counts prescaled clock or sixth general timer overflows.
// - Each time base can instead count an external count input.
// - Each channel picks either time base and capture or compare operation.
// - Each channel owns one pin, input for capture, output in compare modes 1 and 3 or double mode.
// - A capture event copies the chosen count and raises the channel request.
// - Capture triggers on rising, falling or both edges, chosen per channel.
// - Compare channels match continuously and act per their mode.
// - Mode 0 raises only the request, many times per period.
// - Mode 1 toggles the pin on every match, many times per period.
// - Mode 2 raises only the request, at most once per period.
// - Mode 3 sets the pin on match, clears it on overflow, once per period.
// - Double register mode lets two channels toggle one pin on either match.
// - A single event option gives only one edge or pulse in any compare mode.
module channel_timing_unit
  import ctu_pkg::*;
(
  input  wire logic                      REF_CLK,
  input  wire logic                      RST_N,
  input  wire logic                      WB_CYC_I,
  input  wire logic                      WB_STB_I,
  input  wire logic                      WB_WE_I,
  input  wire logic [ctu_pkg::ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]                WB_SEL_I,
  input  wire logic [31:0]               WB_DAT_I,
  output logic      [31:0]               WB_DAT_O,
  output logic                           WB_ACK_O,
  input  wire logic                      SIXTH_GENERAL_TIMER_OVF,
  input  wire logic [1:0]                EXT_CNT_I,
  input  wire logic [ctu_pkg::NUM_CH-1:0] CC_PIN_I,
  output logic      [ctu_pkg::NUM_CH-1:0] CC_PIN_O,
  output logic      [ctu_pkg::NUM_CH-1:0] CC_PIN_OE,
  output logic      [ctu_pkg::NUM_CH-1:0] CC_IRQ
);
  import ctu_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [5:0]        t0_ctrl;
    logic [5:0]        t1_ctrl;
    logic [CNT_W-1:0]  t0_reload;
    logic [CNT_W-1:0]  t1_reload;
    logic              stagger;
    logic [NUM_CH-1:0][5:0] cfg;
    logic              ack;
    logic [31:0]       rdata;
  } top_s;

  top_s s_q, s_d;

  tbase_if tb0 ();
  tbase_if tb1 ();

  logic              req, wr;
  logic [31:0]       wmask, rd;
  logic [3:0]        ch_idx;
  logic              hit_cfg, hit_val;
  logic              t0_ld, t1_ld;
  logic [CNT_W-1:0]  t0_ldv, t1_ldv;
  logic [NUM_CH-1:0] cfg_wr, val_wr, fire, done, pin_o;
  logic [NUM_CH-1:0][CNT_W-1:0] val;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Ack one cycle after the request; a write is applied on that same edge
  always_comb begin
    req     = WB_CYC_I && WB_STB_I && !s_q.ack;
    wr      = req && WB_WE_I;
    wmask   = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    ch_idx  = WB_ADR_I[5:2];
    hit_cfg = WB_ADR_I[7:6] == OFS_CH_CFG[7:6];
    hit_val = WB_ADR_I[7:6] == OFS_CH_VAL[7:6];
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_comb begin
    t0_ld  = 1'b0;
    t1_ld  = 1'b0;
    t0_ldv = 16'(merge({16'h0000, tb0.count}, WB_DAT_I, wmask));
    t1_ldv = 16'(merge({16'h0000, tb1.count}, WB_DAT_I, wmask));
    if (wr && WB_ADR_I == OFS_T0_COUNT) begin
      t0_ld = 1'b1;
    end else if (wr && WB_ADR_I == OFS_T1_COUNT) begin
      t1_ld = 1'b1;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rd = 32'h0000_0000;
    if (WB_ADR_I == OFS_T0_CTRL) begin
      rd = {26'h0, s_q.t0_ctrl};
    end else if (WB_ADR_I == OFS_T0_RELOAD) begin
      rd = {16'h0, s_q.t0_reload};
    end else if (WB_ADR_I == OFS_T0_COUNT) begin
      rd = {16'h0, tb0.count};
    end else if (WB_ADR_I == OFS_T1_CTRL) begin
      rd = {26'h0, s_q.t1_ctrl};
    end else if (WB_ADR_I == OFS_T1_RELOAD) begin
      rd = {16'h0, s_q.t1_reload};
    end else if (WB_ADR_I == OFS_T1_COUNT) begin
      rd = {16'h0, tb1.count};
    end else if (WB_ADR_I == OFS_GLOBAL) begin
      rd = {31'h0, s_q.stagger};
    end else if (hit_cfg) begin
      rd = {25'h0, done[ch_idx], s_q.cfg[ch_idx]};
    end else if (hit_val) begin
      rd = {16'h0, val[ch_idx]};
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.ack   = req;
    s_d.rdata = req ? rd : s_q.rdata;
    cfg_wr    = '0;
    val_wr    = '0;
    if (wr) begin
      if (WB_ADR_I == OFS_T0_CTRL) begin
        s_d.t0_ctrl = 6'(merge({26'h0, s_q.t0_ctrl}, WB_DAT_I, wmask));
      end else if (WB_ADR_I == OFS_T0_RELOAD) begin
        s_d.t0_reload = 16'(merge({16'h0, s_q.t0_reload}, WB_DAT_I, wmask));
      end else if (WB_ADR_I == OFS_T1_CTRL) begin
        s_d.t1_ctrl = 6'(merge({26'h0, s_q.t1_ctrl}, WB_DAT_I, wmask));
      end else if (WB_ADR_I == OFS_T1_RELOAD) begin
        s_d.t1_reload = 16'(merge({16'h0, s_q.t1_reload}, WB_DAT_I, wmask));
      end else if (WB_ADR_I == OFS_GLOBAL) begin
        if (WB_SEL_I[0]) begin
          s_d.stagger = WB_DAT_I[GL_STAG_BIT];
        end
      end else if (hit_cfg) begin
        s_d.cfg[ch_idx] = 6'(merge({26'h0, s_q.cfg[ch_idx]}, WB_DAT_I, wmask));
        cfg_wr[ch_idx]  = 1'b1;
      end else if (hit_val) begin
        val_wr[ch_idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '{t0_ctrl: TC_RST, t1_ctrl: TC_RST, t0_reload: RELOAD_RST,
               t1_reload: RELOAD_RST, stagger: 1'b0, cfg: '0, ack: 1'b0,
               rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign WB_ACK_O = s_q.ack;
  assign WB_DAT_O = s_q.rdata;

  // ----------------------------------------
  // Time bases
  // ----------------------------------------
  time_base u_tb0 (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .run     (s_q.t0_ctrl[TC_RUN_BIT]),
    .src     (src_e'(s_q.t0_ctrl[TC_SRC_LSB +: 2])),
    .presc   (s_q.t0_ctrl[TC_PRESC_LSB +: 3]),
    .stagger (s_q.stagger),
    .reload  (s_q.t0_reload),
    .ld      (t0_ld),
    .ld_val  (t0_ldv),
    .gt6_ovf (SIXTH_GENERAL_TIMER_OVF),
    .ext_cnt (EXT_CNT_I[0]),
    .tb      (tb0.src)
  );

  time_base u_tb1 (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .run     (s_q.t1_ctrl[TC_RUN_BIT]),
    .src     (src_e'(s_q.t1_ctrl[TC_SRC_LSB +: 2])),
    .presc   (s_q.t1_ctrl[TC_PRESC_LSB +: 3]),
    .stagger (s_q.stagger),
    .reload  (s_q.t1_reload),
    .ld      (t1_ld),
    .ld_val  (t1_ldv),
    .gt6_ovf (SIXTH_GENERAL_TIMER_OVF),
    .ext_cnt (EXT_CNT_I[1]),
    .tb      (tb1.src)
  );

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  // Channel k pairs with k+8 in double mode; only the lower pin toggles on both matches
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic partner;
      logic oe;
      if (g < HALF_CH) begin : g_lo
        assign partner = fire[g + HALF_CH];
      end else begin : g_hi
        assign partner = 1'b0;
      end
      cc_channel u_ch (
        .clk          (REF_CLK),
        .rst_n        (RST_N),
        .ta           (tb0.snk),
        .tbb          (tb1.snk),
        .cfg          (s_q.cfg[g]),
        .cfg_wr       (cfg_wr[g]),
        .val_wr       (val_wr[g]),
        .val_wdata    (16'(merge({16'h0, val[g]}, WB_DAT_I, wmask))),
        .pin_i        (CC_PIN_I[g]),
        .partner_fire (partner),
        .val          (val[g]),
        .pin_o        (pin_o[g]),
        .pin_oe       (oe),
        .irq          (CC_IRQ[g]),
        .fire         (fire[g]),
        .done         (done[g])
      );
      assign CC_PIN_O[g]  = pin_o[g];
      assign CC_PIN_OE[g] = oe;
    end
  endgenerate
endmodule : channel_timing_unit
`default_nettype wire

// *** pkg/ctu_pkg.sv ***
// Constants and types shared by the channel timing unit.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
package ctu_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CH  = 16;
  localparam int HALF_CH = 8;
  localparam int CNT_W   = 16;
  localparam int ADR_W   = 8;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_T0_CTRL   = 8'h00;
  localparam logic [7:0] OFS_T0_RELOAD = 8'h04;
  localparam logic [7:0] OFS_T0_COUNT  = 8'h08;
  localparam logic [7:0] OFS_T1_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_T1_RELOAD = 8'h10;
  localparam logic [7:0] OFS_T1_COUNT  = 8'h14;
  localparam logic [7:0] OFS_GLOBAL    = 8'h18;
  localparam logic [7:0] OFS_CH_CFG    = 8'h40;
  localparam logic [7:0] OFS_CH_VAL    = 8'h80;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TC_PRESC_LSB = 0;
  localparam int TC_SRC_LSB   = 3;
  localparam int TC_RUN_BIT   = 5;
  localparam int GL_STAG_BIT  = 0;
  localparam int CF_MODE_LSB  = 0;
  localparam int CF_TSEL_BIT  = 3;
  localparam int CF_SINGLE_BIT = 4;
  localparam int CF_DBL_BIT   = 5;
  localparam int CF_DONE_BIT  = 6;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [5:0]  TC_RST     = 6'h00;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [5:0]  CFG_RST    = 6'h00;
  localparam logic [2:0]  STAG_PRESC = 3'h3;

  typedef enum logic [1:0] {SRC_PRESC, SRC_GT6, SRC_EXT, SRC_OFF} src_e;
  typedef enum logic [2:0] {
    M_OFF, M_CAP_RISE, M_CAP_FALL, M_CAP_BOTH,
    M_CMP0, M_CMP1, M_CMP2, M_CMP3
  } mode_e;
endpackage : ctu_pkg

// *** pkg/tbase_if.sv ***
// Time base bundle: current count plus update and overflow pulses.
// Assumes one producer (time_base) and any number of channel readers.
`timescale 1ns/1ps
`default_nettype none
interface tbase_if;
  logic [15:0] count;
  logic        upd;
  logic        ovf;
  modport src (output count, output upd, output ovf);
  modport snk (input count, input upd, input ovf);
endinterface : tbase_if
`default_nettype wire

// *** core/time_base.sv ***
// One reloadable 16-bit time base with selectable count source.
// Assumes all inputs synchronous to REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module time_base
  import ctu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              run,
  input  wire src_e              src,
  input  wire logic [2:0]        presc,
  input  wire logic              stagger,
  input  wire logic [CNT_W-1:0]  reload,
  input  wire logic              ld,
  input  wire logic [CNT_W-1:0]  ld_val,
  input  wire logic              gt6_ovf,
  input  wire logic              ext_cnt,
  tbase_if.src                   tb
);
  typedef struct packed {
    logic [6:0]       div;
    logic [CNT_W-1:0] cnt;
    logic             ext_prev;
    logic             upd;
    logic             ovf;
  } tb_s;

  tb_s s_q, s_d;
  logic [2:0] eff;
  logic [6:0] mask;
  logic       tick;

  always_comb begin
    // Staggered channels need eight cycles, so the divider floors at 8
    eff  = (stagger && presc < STAG_PRESC) ? STAG_PRESC : presc;
    mask = 7'((8'h01 << eff) - 8'h01);
    case (src)
      SRC_PRESC: tick = (s_q.div & mask) == 7'h00;
      SRC_GT6:   tick = gt6_ovf;
      SRC_EXT:   tick = ext_cnt & ~s_q.ext_prev;
      default:   tick = 1'b0;
    endcase
    s_d          = s_q;
    s_d.div      = 7'(s_q.div + 7'h01);
    s_d.ext_prev = ext_cnt;
    s_d.upd      = 1'b0;
    s_d.ovf      = 1'b0;
    if (ld) begin
      s_d.cnt = ld_val;
      s_d.upd = 1'b1;
    end else if (run && tick) begin
      s_d.upd = 1'b1;
      if (s_q.cnt == 16'hffff) begin
        s_d.cnt = reload;
        s_d.ovf = 1'b1;
      end else begin
        s_d.cnt = 16'(s_q.cnt + 16'h0001);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tb.count = s_q.cnt;
  assign tb.upd   = s_q.upd;
  assign tb.ovf   = s_q.ovf;
endmodule : time_base
`default_nettype wire

// *** core/cc_channel.sv ***
// One capture/compare channel with its own pin.
// Assumes both time bases and the pin are synchronous to REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module cc_channel
  import ctu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  tbase_if.snk                   ta,
  tbase_if.snk                   tbb,
  input  wire logic [5:0]        cfg,
  input  wire logic              cfg_wr,
  input  wire logic              val_wr,
  input  wire logic [CNT_W-1:0]  val_wdata,
  input  wire logic              pin_i,
  input  wire logic              partner_fire,
  output logic [CNT_W-1:0]       val,
  output logic                   pin_o,
  output logic                   pin_oe,
  output logic                   irq,
  output logic                   fire,
  output logic                   done
);
  typedef struct packed {
    logic [CNT_W-1:0] val;
    logic             pin;
    logic             armed;
    logic             done;
    logic             prev;
    logic             irq;
  } ch_s;

  ch_s s_q, s_d;
  mode_e            mode;
  logic             tsel, single, dbl;
  logic [CNT_W-1:0] cnt;
  logic             upd, ovf, cap, match, toggle;

  always_comb begin
    mode   = mode_e'(cfg[CF_MODE_LSB +: 3]);
    tsel   = cfg[CF_TSEL_BIT];
    single = cfg[CF_SINGLE_BIT];
    dbl    = cfg[CF_DBL_BIT];
    cnt    = tsel ? tbb.count : ta.count;
    upd    = tsel ? tbb.upd : ta.upd;
    ovf    = tsel ? tbb.ovf : ta.ovf;
    case (mode)
      M_CAP_RISE: cap = pin_i & ~s_q.prev;
      M_CAP_FALL: cap = ~pin_i & s_q.prev;
      M_CAP_BOTH: cap = pin_i ^ s_q.prev;
      default:    cap = 1'b0;
    endcase
    match = (mode >= M_CMP0) && upd && cnt == s_q.val && !s_q.done;
    // Reload on overflow re-arms before the fresh count is compared
    if (mode == M_CMP2 || mode == M_CMP3) begin
      fire = match && (s_q.armed || ovf);
    end else begin
      fire = match;
    end
    toggle = (fire && mode == M_CMP1) || (dbl && !s_q.done && (fire || partner_fire));

    s_d      = s_q;
    s_d.prev = pin_i;
    s_d.irq  = 1'b0;
    if (ovf) begin
      s_d.armed = 1'b1;
      if (mode == M_CMP3) begin
        s_d.pin = 1'b0;
      end
    end
    if (val_wr) begin
      s_d.val = val_wdata;
    end
    if (cfg_wr) begin
      s_d.done  = 1'b0;
      s_d.armed = 1'b1;
    end
    if (cap) begin
      s_d.val = cnt;
      s_d.irq = 1'b1;
    end
    if (fire) begin
      s_d.irq = 1'b1;
      if (mode == M_CMP2 || mode == M_CMP3) begin
        s_d.armed = 1'b0;
      end
      if (mode == M_CMP3) begin
        s_d.pin = 1'b1;
      end
    end
    if (toggle) begin
      s_d.pin = ~s_q.pin;
    end
    if ((fire || (dbl && partner_fire)) && single && !s_q.done) begin
      s_d.done = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{val: '0, pin: 1'b0, armed: 1'b1, done: 1'b0, prev: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign val    = s_q.val;
  assign pin_o  = s_q.pin;
  assign pin_oe = (mode == M_CMP1) || (mode == M_CMP3) || dbl;
  assign irq    = s_q.irq;
  assign done   = s_q.done;
endmodule : cc_channel
`default_nettype wire

// *** tb/ctu_assertions.sv ***
// Checker on the channel timing unit ports: bus handshake, pin drive, capture.
// Assumes word-aligned accesses; channel config is shadowed from bus writes.
`timescale 1ns/1ps
`default_nettype none
module ctu_checker
(
  input wire logic                       REF_CLK,
  input wire logic                       RST_N,
  input wire logic                       WB_CYC_I,
  input wire logic                       WB_STB_I,
  input wire logic                       WB_WE_I,
  input wire logic [ctu_pkg::ADR_W-1:0]  WB_ADR_I,
  input wire logic [3:0]                 WB_SEL_I,
  input wire logic [31:0]                WB_DAT_I,
  input wire logic [31:0]                WB_DAT_O,
  input wire logic                       WB_ACK_O,
  input wire logic [ctu_pkg::NUM_CH-1:0] CC_PIN_I,
  input wire logic [ctu_pkg::NUM_CH-1:0] CC_PIN_OE,
  input wire logic [ctu_pkg::NUM_CH-1:0] CC_IRQ
);
  import ctu_pkg::*;
  logic [5:0] cfg_q [NUM_CH];
  logic       cfg_wr;
  assign cfg_wr = WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I[7:6] == 2'h1;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_CH; i++) cfg_q[i] <= CFG_RST;
    end else if (cfg_wr) begin
      cfg_q[WB_ADR_I[5:2]] <= WB_DAT_I[5:0];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  property p_ack_next; s_take |=> WB_ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hold; !WB_ACK_O |-> $stable(WB_DAT_O); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
  property p_unmapped;
    WB_ACK_O && !WB_WE_I && (WB_ADR_I inside {[8'h1c:8'h3f], [8'hc0:8'hff]}) |-> WB_DAT_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_quiet; $rose(RST_N) |-> !WB_ACK_O && CC_IRQ == 16'h0 && CC_PIN_OE == 16'h0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [2:0] m;
    assign m = cfg_q[i][2:0];
    sequence s_cap_edge;
      (m == M_CAP_RISE || m == M_CAP_BOTH) && $rose(CC_PIN_I[i]) ||
      (m == M_CAP_FALL || m == M_CAP_BOTH) && $fell(CC_PIN_I[i]);
    endsequence
    property p_cap; s_cap_edge |-> ##[1:2] CC_IRQ[i]; endproperty
    a_cap: assert property (p_cap) else $error("capture edge gave no request");
    property p_oe; !WB_ACK_O |-> CC_PIN_OE[i] == (m == M_CMP1 || m == M_CMP3 || cfg_q[i][5]); endproperty
    a_oe: assert property (p_oe) else $error("pin enable disagrees with mode");
  end
endmodule : ctu_checker
bind channel_timing_unit ctu_checker u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CC_PIN_I(CC_PIN_I), .CC_PIN_OE(CC_PIN_OE), .CC_IRQ(CC_IRQ));
`default_nettype wire

// *** tb/ext_pin_model.sv ***
// External signal sources on the channel pins.
// Assumes the bench resolves pin level from the unit's output enables.
`timescale 1ns/1ps
`default_nettype none
module ext_pin_model
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [ctu_pkg::NUM_CH-1:0] want,
  input  wire logic [3:0]                 lag,
  output logic      [ctu_pkg::NUM_CH-1:0] level
);
  import ctu_pkg::*;
  logic [3:0] wait_q;
  // Slow sources follow the request only after lag cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level  <= '0;
      wait_q <= 4'h0;
    end else if (want == level) begin
      wait_q <= 4'h0;
    end else if (wait_q >= lag) begin
      level  <= want;
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : ext_pin_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the channel timing unit.
// Assumes a one-cycle bus answer and pins resolved from the output enables.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ctu_pkg::*;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [7:0]  adr    = 8'h00;
  logic [3:0]  sel    = 4'h0;
  logic [31:0] wdat   = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        gt6    = 1'b0;
  logic [1:0]  ext    = 2'h0;
  logic [15:0] want   = 16'h0;
  logic [3:0]  lag    = 4'h0;
  logic [15:0] ext_lvl;
  logic [15:0] pin_in;
  logic [15:0] pin_o;
  logic [15:0] pin_oe;
  logic [15:0] irq;
  logic [15:0] lfsr_q = 16'h2de2;
  logic [3:0]  mon_ch = 4'h0;
  logic        prev_pin;
  int          fails = 0;
  int          num_checks = 0;
  int          irq_n;
  int          edge_n;
  int          ex_irq [6] = '{3, 3, 2, 2, 1, 1};
  int          ex_edge [6] = '{0, 3, 0, 3, 1, 2};

  always #12.5 clk = ~clk;
  assign pin_in = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
  ext_pin_model u_ext (.clk(clk), .rst_n(rst_n), .want(want), .lag(lag), .level(ext_lvl));
  channel_timing_unit u_dut (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SIXTH_GENERAL_TIMER_OVF(gt6), .EXT_CNT_I(ext), .CC_PIN_I(pin_in), .CC_PIN_O(pin_o),
    .CC_PIN_OE(pin_oe), .CC_IRQ(irq));

  always @(posedge clk) begin
    irq_n += int'(irq[mon_ch]);
    if (pin_o[mon_ch] !== prev_pin) edge_n++;
    prev_pin = pin_o[mon_ch];
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd
  function automatic logic takes(input logic [2:0] m, input logic rise);
    return rise ? (m != M_CAP_FALL) : (m != M_CAP_RISE);
  endfunction : takes
  function automatic logic [2:0] cmp_mode(input int k);
    return (k < 4) ? 3'(4 + k) : ((k == 4) ? 3'h5 : 3'h7);
  endfunction : cmp_mode
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    // No own limit: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 4'hf, q);
  endtask : rd
  task automatic mon_reset(input logic [3:0] ch);
    @(negedge clk);
    mon_ch = ch;
    irq_n = 0;
    edge_n = 0;
    prev_pin = pin_o[ch];
  endtask : mon_reset
  task automatic stop_test();
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic [31:0] q2;
    logic [31:0] vexp;
    logic [15:0] r;
    logic [15:0] v [2];
    logic [7:0]  to;
    logic [7:0]  co;
    logic [3:0]  ch;
    logic        t;
    int          nexp;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_T0_CTRL, q);
    check("t0 ctrl", q, {26'h0, TC_RST});
    rd(OFS_T1_RELOAD, q);
    check("t1 reload", q, {16'h0, RELOAD_RST});
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, q);
    check("unmapped", q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      to = (i > 2) ? 8'h0c : 8'h00;
      r = rnd();
      wr(OFS_T0_RELOAD + to, {16'h0, r});
      wr(OFS_T0_RELOAD + to, 32'h0000_00a5, 4'h1);
      rd(OFS_T0_RELOAD + to, q);
      check("reload", q, {16'h0, r[15:8], 8'ha5});
      wr(OFS_T0_CTRL + to, {26'h0, 1'b1, 2'(i % 3), 3'h0});
      wr(OFS_T0_COUNT + to, 32'h0);
      if (i % 3 == 0) begin
        rd(OFS_T0_COUNT + to, q);
        rd(OFS_T0_COUNT + to, q2);
        check("count step", q2 - q, 32'h3);
      end else begin
        nexp = int'(r[2:0]) + 1;
        repeat (nexp) begin
          @(posedge clk);
          if (i % 3 == 1) gt6 <= 1'b1;
          else ext[i > 2] <= 1'b1;
          @(posedge clk);
          gt6 <= 1'b0;
          ext <= 2'h0;
        end
        repeat (4) @(posedge clk);
        rd(OFS_T0_COUNT + to, q);
        check("event count", q, 32'(nexp));
      end
      wr(OFS_T0_CTRL + to, 32'h18);
    end
    // Latches eight cycles apart see exactly one staggered tick
    wr(OFS_GLOBAL, 32'h1);
    wr(OFS_T0_CTRL, 32'h20);
    rd(OFS_T0_COUNT, q);
    repeat (5) @(posedge clk);
    rd(OFS_T0_COUNT, q2);
    check("stagger step", q2 - q, 32'h1);
    wr(OFS_T0_CTRL, 32'h18);
    wr(OFS_GLOBAL, 32'h0);
    wr(OFS_T0_COUNT, 32'hffc8);
    wr(OFS_CH_VAL, 32'hffd0);
    wr(OFS_CH_VAL + 8'h20, 32'hffe0);
    wr(OFS_CH_CFG + 8'h20, 32'h4);
    wr(OFS_CH_CFG, 32'h24);
    mon_reset(4'h0);
    wr(OFS_T0_CTRL, 32'h20);
    repeat (40) @(posedge clk);
    wr(OFS_T0_CTRL, 32'h18);
    check("double edges", 32'(edge_n), 32'h2);
    wr(OFS_CH_CFG, 32'h0);
    wr(OFS_CH_CFG + 8'h20, 32'h0);
    r = rnd();
    ch = r[3:0];
    t = r[4];
    co = {2'h0, ch, 2'h0};
    v[0] = rnd();
    v[1] = rnd();
    wr(OFS_T0_COUNT, {16'h0, v[0]});
    wr(OFS_T1_COUNT, {16'h0, v[1]});
    for (int m = 1; m < 4; m++) begin
      lag <= 4'(m);
      wr(OFS_CH_VAL + co, 32'h0);
      wr(OFS_CH_CFG + co, {28'h0, t, 3'(m)});
      mon_reset(ch);
      vexp = 32'h0;
      nexp = 0;
      for (int e = 1; e >= 0; e--) begin
        @(posedge clk);
        want[ch] <= e[0];
        repeat (10) @(posedge clk);
        if (takes(3'(m), e[0])) begin
          vexp = {16'h0, v[t]};
          nexp++;
        end
        rd(OFS_CH_VAL + co, q);
        check("capture value", q, vexp);
      end
      check("capture requests", 32'(irq_n), 32'(nexp));
    end
    wr(OFS_CH_CFG + co, 32'h0);
    // Count is rewound once per run: a second match inside the same period
    for (int k = 0; k < 6; k++) begin
      ch = r[3:0] + 4'(k);
      co = {2'h0, ch, 2'h0};
      t = r[k + 5];
      to = t ? 8'h0c : 8'h00;
      wr(OFS_T0_RELOAD + to, 32'hffc0);
      wr(OFS_T0_COUNT + to, 32'hffc8);
      wr(OFS_CH_VAL + co, 32'hffd0);
      wr(OFS_CH_CFG + co, {27'h0, k > 3, t, cmp_mode(k)});
      mon_reset(ch);
      wr(OFS_T0_CTRL + to, 32'h20);
      repeat (30) @(posedge clk);
      wr(OFS_T0_COUNT + to, 32'hffc8);
      repeat (80) @(posedge clk);
      wr(OFS_T0_CTRL + to, 32'h18);
      check("compare requests", 32'(irq_n), 32'(ex_irq[k]));
      check("pin edges", 32'(edge_n), 32'(ex_edge[k]));
      if (k > 3) begin
        rd(OFS_CH_CFG + co, q);
        check("done set", 32'(q[6]), 32'h1);
        wr(OFS_CH_CFG + co, {27'h0, 1'b1, t, cmp_mode(k)});
        rd(OFS_CH_CFG + co, q);
        check("done cleared", 32'(q[6]), 32'h0);
      end
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
